// ---- power_factor_kvar_protection.sv ----
// How it works
// - Induction motor watts and vars reported positive
// - Synchronous motor: absorbed vars plus, generated minus
// - Reverse run corrects phase order before power
// - Elements inactive without the hardware option
// - Per-element start hold-off 0 to 5000 s
// - Alarm and trip each Off, Latched, Unlatched
// - Alarm routes to alarm, aux one, aux two
// - Trip routes to trip, aux one, aux two
// - Power factor levels 0.05 to 0.99
// - Pickup delays 0.1 to 255.0 s
// - Kvar levels 1 to 25000 kvar
// - Optional event record of alarm pickups
// - Lead alarm/trip: leading pf below level
// - Lag alarm/trip: lagging pf below level
// - Positive kvar above level for delay
// - Generated kvar beyond negative level for delay
// - Power factor paths suppressed during hold-off
// - Kvar paths suppressed during hold-off
// - Lead defaults: alarm 0.30, trip 0.30
// - Lag defaults: alarm 0.85, trip 0.80
// - Positive kvar alarm default 10 kvar
// - Negative kvar defaults: trip 25, alarm 10
// - Zero hold-off never blocks; else stopped blocks
//
// Decided for this implementation: the plain strobed port and the register addresses.
`timescale 1ns/1ps

module power_factor_kvar_protection #(
  parameter int TENTH_CYCLES = pfvar_pkg::TENTH_CYCLES
) (
  // Clock and reset
  input wire logic mclk_i,
  input wire logic sys_rst_i,
  // Register port
  input wire logic [pfvar_pkg::ADDR_W-1:0] reg_addr_i,
  input wire logic [pfvar_pkg::DATA_W-1:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  output logic [pfvar_pkg::DATA_W-1:0] reg_rdata_o,
  // Metering front end and motor state
  input pfvar_pkg::meter_type meter_i,
  input wire logic reverse_run_i,
  input wire logic motor_running_i,
  input wire logic motor_start_i,
  input wire logic option_installed_i,
  input wire logic latch_reset_i,
  // Relays
  output logic alarm_relay_o,
  output logic trip_relay_o,
  output logic auxiliary_output_one_o,
  output logic auxiliary_output_two_o,
  // Element state and events
  output logic [pfvar_pkg::ELEMENTS-1:0] alarm_o,
  output logic [pfvar_pkg::ELEMENTS-1:0] trip_o,
  output logic [pfvar_pkg::ELEMENTS-1:0] event_o,
  output pfvar_pkg::meter_type reported_o
);

  // Tick counter widths follow the divider ratios
  localparam int NE = pfvar_pkg::ELEMENTS;
  localparam int TW = $clog2(TENTH_CYCLES + 1);
  localparam int SW = $clog2(pfvar_pkg::TENTHS_PER_S + 1);
  localparam logic [TW-1:0] TENTH_LAST = TW'(TENTH_CYCLES - 1);
  localparam logic [SW-1:0] SEC_LAST = SW'(pfvar_pkg::TENTHS_PER_S - 1);

  // ****************
  // Time base
  // ****************
  logic [TW-1:0] tenth_cnt;
  logic [SW-1:0] sec_cnt;
  logic tenth_tick;
  logic sec_tick;

  // Ticks are decoded combinationally; both are one-cycle enables
  assign tenth_tick = (tenth_cnt == TENTH_LAST);
  assign sec_tick = tenth_tick && (sec_cnt == SEC_LAST);

  // Counters start at reset, so the first tick lands a tenth later
  // Tenth-second enable; all pickup delays step in 0.1 s
  always_ff @(posedge mclk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      tenth_cnt <= '0;
    end else if (tenth_tick) begin
      tenth_cnt <= '0;
    end else begin
      tenth_cnt <= tenth_cnt + TW'(1);
    end
  end

  // One-second enable for the hold-off counters
  // Second steps let a hold-off end up to one second early
  always_ff @(posedge mclk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      sec_cnt <= '0;
    end else if (sec_tick) begin
      sec_cnt <= '0;
    end else if (tenth_tick) begin
      sec_cnt <= sec_cnt + SW'(1);
    end
  end

  // ****************
  // Sign convention
  // ****************
  // Induction motor power arrives as plus watts and plus vars, and a
  // synchronous motor that generates vars as plus watts, minus vars;
  // both pass unchanged in forward running.
  // Swapped voltage sequence flips only the reactive part, so the
  // correction negates vars and the lead/lag sense; watts pass as is.
  always_ff @(posedge mclk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      reported_o <= '0;
    end else begin
      reported_o.kw <= meter_i.kw;
      reported_o.pf <= meter_i.pf;
      if (reverse_run_i) begin
        reported_o.kvar <= -meter_i.kvar;
        reported_o.leading <= !meter_i.leading;
      end else begin
        reported_o.kvar <= meter_i.kvar;
        reported_o.leading <= meter_i.leading;
      end
    end
  end

  // ****************
  // Level comparison
  // ****************
  logic [pfvar_pkg::LEVEL_W-1:0] pf_ext;
  logic [pfvar_pkg::LEVEL_W-1:0] kvar_pos;
  logic [pfvar_pkg::LEVEL_W-1:0] kvar_neg;
  logic signed [pfvar_pkg::KVAR_W-1:0] kvar_inv;

  // Power factor in hundredths, widened to the level width
  assign pf_ext = pfvar_pkg::LEVEL_W'(reported_o.pf);
  assign kvar_inv = -reported_o.kvar;
  // Magnitudes on each side of zero; the other side reads as zero
  assign kvar_pos = reported_o.kvar[pfvar_pkg::KVAR_W-1] ? '0
                  : reported_o.kvar[pfvar_pkg::LEVEL_W-1:0];
  // Full negative scale has no positive twin and reads as zero; it
  // lies far beyond any settable level
  assign kvar_neg = reported_o.kvar[pfvar_pkg::KVAR_W-1] ? kvar_inv[pfvar_pkg::LEVEL_W-1:0]
                  : '0;

  // ****************
  // Settings, hold-off and paths
  // ****************
  // Per-element storage, indexed by element number
  pfvar_pkg::elem_cfg_type cfg [NE];
  pfvar_pkg::path_cfg_type alarm_cfg [NE];
  pfvar_pkg::path_cfg_type trip_cfg [NE];
  logic [pfvar_pkg::HOLD_W-1:0] hold_cnt [NE];
  logic [NE-1:0] blocked;
  logic [NE-1:0] alarm_rise;
  logic [NE-1:0] alarm_cond;
  logic [NE-1:0] trip_cond;
  logic clear_all;

  // Missing option keeps every element cleared and idle
  // Reset held high cannot beat a condition that still picks up
  assign clear_all = latch_reset_i || !option_installed_i;

  // Alarm and trip comparisons kept separate per element
  always_comb begin
    alarm_cond[pfvar_pkg::EL_LEAD] = reported_o.leading
      && (pf_ext < alarm_cfg[pfvar_pkg::EL_LEAD].level);
    trip_cond[pfvar_pkg::EL_LEAD] = reported_o.leading
      && (pf_ext < trip_cfg[pfvar_pkg::EL_LEAD].level);
    alarm_cond[pfvar_pkg::EL_LAG] = !reported_o.leading
      && (pf_ext < alarm_cfg[pfvar_pkg::EL_LAG].level);
    trip_cond[pfvar_pkg::EL_LAG] = !reported_o.leading
      && (pf_ext < trip_cfg[pfvar_pkg::EL_LAG].level);
    alarm_cond[pfvar_pkg::EL_POSV] = kvar_pos
      > alarm_cfg[pfvar_pkg::EL_POSV].level;
    trip_cond[pfvar_pkg::EL_POSV] = kvar_pos
      > trip_cfg[pfvar_pkg::EL_POSV].level;
    alarm_cond[pfvar_pkg::EL_NEGV] = kvar_neg
      > alarm_cfg[pfvar_pkg::EL_NEGV].level;
    trip_cond[pfvar_pkg::EL_NEGV] = kvar_neg
      > trip_cfg[pfvar_pkg::EL_NEGV].level;
  end

  for (genvar e = 0; e < NE; e++) begin : g_elem
    localparam logic [pfvar_pkg::ADDR_W-1:0] BASE = pfvar_pkg::ADDR_W'(e * pfvar_pkg::ELEM_STRIDE);
    logic armed;

    // Settings registers, written whole word
    // No range check: software keeps levels and delays in their spans
    always_ff @(posedge mclk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
        cfg[e] <= '{events: 1'b0, trip_relays: pfvar_pkg::RELAY_DEF,
                    alarm_relays: pfvar_pkg::RELAY_DEF, trip_mode: pfvar_pkg::MODE_OFF,
                    alarm_mode: pfvar_pkg::MODE_OFF, holdoff: pfvar_pkg::HOLD_DEF};
        alarm_cfg[e] <= '{delay: pfvar_pkg::DELAY_DEF, level: pfvar_pkg::ALARM_LVL_DEF[e]};
        trip_cfg[e] <= '{delay: pfvar_pkg::DELAY_DEF, level: pfvar_pkg::TRIP_LVL_DEF[e]};
      end else if (reg_wr_i) begin
        if (reg_addr_i == BASE + pfvar_pkg::OFS_CTRL) begin
          cfg[e] <= pfvar_pkg::elem_cfg_type'(reg_wdata_i[$bits(pfvar_pkg::elem_cfg_type)-1:0]);
        end
        if (reg_addr_i == BASE + pfvar_pkg::OFS_ALARM) begin
          alarm_cfg[e] <= pfvar_pkg::path_cfg_type'(reg_wdata_i[$bits(pfvar_pkg::path_cfg_type)-1:0]);
        end
        if (reg_addr_i == BASE + pfvar_pkg::OFS_TRIP) begin
          trip_cfg[e] <= pfvar_pkg::path_cfg_type'(reg_wdata_i[$bits(pfvar_pkg::path_cfg_type)-1:0]);
        end
      end
    end

    // Hold-off count loaded by a detected start, counted in seconds
    // A new start reloads the count even while one is running
    always_ff @(posedge mclk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
        hold_cnt[e] <= '0;
      end else if (motor_start_i) begin
        hold_cnt[e] <= cfg[e].holdoff;
      end else if (sec_tick && hold_cnt[e] != '0) begin
        hold_cnt[e] <= hold_cnt[e] - pfvar_pkg::HOLD_W'(1);
      end
    end

    // Zero hold-off never blocks, even with the motor stopped; the start
    // pulse blocks its own cycle, before the count has loaded
    assign blocked[e] = (cfg[e].holdoff != '0)
                      && (!motor_running_i || motor_start_i || hold_cnt[e] != '0);
    // Latched outputs survive a new hold-off; only latch reset, option removal or Off clears
    assign armed = option_installed_i && !blocked[e];

    // Both paths share arming but keep their own timers
    pickup_path #(.DW(pfvar_pkg::DELAY_W)) u_alarm (
      .mclk_i(mclk_i),
      .sys_rst_i(sys_rst_i),
      .tick_i(tenth_tick),
      .cond_i(alarm_cond[e]),
      .armed_i(armed),
      .clear_i(clear_all),
      .mode_i(cfg[e].alarm_mode),
      .delay_i(alarm_cfg[e].delay),
      .active_o(alarm_o[e]),
      .rise_o(alarm_rise[e])
    );

    // Trip pickups are not logged as events
    pickup_path #(.DW(pfvar_pkg::DELAY_W)) u_trip (
      .mclk_i(mclk_i),
      .sys_rst_i(sys_rst_i),
      .tick_i(tenth_tick),
      .cond_i(trip_cond[e]),
      .armed_i(armed),
      .clear_i(clear_all),
      .mode_i(cfg[e].trip_mode),
      .delay_i(trip_cfg[e].delay),
      .active_o(trip_o[e]),
      .rise_o()
    );

    // Event pulse on each new alarm pickup when recording is on
    // A latched alarm that stays set logs once, not every cycle
    always_ff @(posedge mclk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
        event_o[e] <= 1'b0;
      end else begin
        event_o[e] <= alarm_rise[e] && cfg[e].events;
      end
    end
  end

  // ****************
  // Relay routing
  // ****************
  logic [pfvar_pkg::RELAY_W-1:0] alarm_mask;
  logic [pfvar_pkg::RELAY_W-1:0] trip_mask;

  // Any element may share any relay; contributions are ORed
  // A shared relay stays energised while any contributor is active
  always_comb begin
    alarm_mask = '0;
    trip_mask = '0;
    for (int i = 0; i < NE; i++) begin
      alarm_mask = alarm_mask
                 | (cfg[i].alarm_relays & {pfvar_pkg::RELAY_W{alarm_o[i]}});
      trip_mask = trip_mask
                | (cfg[i].trip_relays & {pfvar_pkg::RELAY_W{trip_o[i]}});
    end
  end

  // Relays registered so a glitch in routing never pulses a coil
  always_ff @(posedge mclk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      alarm_relay_o <= 1'b0;
      trip_relay_o <= 1'b0;
      auxiliary_output_one_o <= 1'b0;
      auxiliary_output_two_o <= 1'b0;
    end else begin
      alarm_relay_o <= alarm_mask[pfvar_pkg::RLY_MAIN];
      trip_relay_o <= trip_mask[pfvar_pkg::RLY_MAIN];
      auxiliary_output_one_o <= alarm_mask[pfvar_pkg::RLY_AUXILIARY_OUTPUT_ONE]
                                || trip_mask[pfvar_pkg::RLY_AUXILIARY_OUTPUT_ONE];
      auxiliary_output_two_o <= alarm_mask[pfvar_pkg::RLY_AUXILIARY_OUTPUT_TWO]
                                || trip_mask[pfvar_pkg::RLY_AUXILIARY_OUTPUT_TWO];
    end
  end

  // ****************
  // Read port
  // ****************
  logic [pfvar_pkg::DATA_W-1:0] next_rdata;
  logic [1:0] rd_elem;

  assign rd_elem = reg_addr_i[5:4];

  // Element index comes from the address; the top of the map is shared
  // Read decode; unmapped addresses return zero
  always_comb begin
    next_rdata = '0;
    if (reg_addr_i < pfvar_pkg::OFS_STATUS) begin
      unique case (reg_addr_i[3:0])
        pfvar_pkg::OFS_CTRL[3:0]: next_rdata = pfvar_pkg::DATA_W'(cfg[rd_elem]);
        pfvar_pkg::OFS_ALARM[3:0]: next_rdata = pfvar_pkg::DATA_W'(alarm_cfg[rd_elem]);
        pfvar_pkg::OFS_TRIP[3:0]: next_rdata = pfvar_pkg::DATA_W'(trip_cfg[rd_elem]);
        default: next_rdata = '0;
      endcase
    end else if (reg_addr_i == pfvar_pkg::OFS_STATUS) begin
      next_rdata = pfvar_pkg::DATA_W'({option_installed_i, blocked, trip_o, alarm_o});
    end else if (reg_addr_i == pfvar_pkg::OFS_METER) begin
      next_rdata = {reported_o.kw, reported_o.kvar};
    end
  end

  // Read data valid the cycle after the strobe only
  // Zero between reads lets read lines be ORed with other blocks
  always_ff @(posedge mclk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      reg_rdata_o <= '0;
    end else if (reg_rd_i) begin
      reg_rdata_o <= next_rdata;
    end else begin
      reg_rdata_o <= '0;
    end
  end

endmodule : power_factor_kvar_protection

// ---- pfvar_pkg.sv ----
package pfvar_pkg;

  // ****************
  // Sizes
  // ****************
  localparam int ELEMENTS = 4;
  localparam int PF_W = 7;
  localparam int KVAR_W = 16;
  localparam int LEVEL_W = 15;
  localparam int DELAY_W = 12;
  localparam int HOLD_W = 13;
  localparam int RELAY_W = 3;
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;

  // ****************
  // Element indices
  // ****************
  localparam int EL_LEAD = 0;
  localparam int EL_LAG = 1;
  localparam int EL_POSV = 2;
  localparam int EL_NEGV = 3;

  // Relay mask bits: main relay, first aux, second aux
  localparam int RLY_MAIN = 0;
  localparam int RLY_AUXILIARY_OUTPUT_ONE = 1;
  localparam int RLY_AUXILIARY_OUTPUT_TWO = 2;

  // ****************
  // Types
  // ****************
  typedef enum logic [1:0] {MODE_OFF, MODE_LATCHED, MODE_UNLATCHED} mode_type;

  typedef struct packed {
    logic events;
    logic [RELAY_W-1:0] trip_relays;
    logic [RELAY_W-1:0] alarm_relays;
    mode_type trip_mode;
    mode_type alarm_mode;
    logic [HOLD_W-1:0] holdoff;
  } elem_cfg_type;

  typedef struct packed {
    logic [DELAY_W-1:0] delay;
    logic [LEVEL_W-1:0] level;
  } path_cfg_type;

  typedef struct packed {
    logic leading;
    logic [PF_W-1:0] pf;
    logic signed [KVAR_W-1:0] kvar;
    logic signed [KVAR_W-1:0] kw;
  } meter_type;

  // ****************
  // Register map
  // ****************
  localparam logic [ADDR_W-1:0] OFS_CTRL = 8'h00;
  localparam logic [ADDR_W-1:0] OFS_ALARM = 8'h04;
  localparam logic [ADDR_W-1:0] OFS_TRIP = 8'h08;
  localparam logic [ADDR_W-1:0] ELEM_STRIDE = 8'h10;
  localparam logic [ADDR_W-1:0] OFS_STATUS = 8'h40;
  localparam logic [ADDR_W-1:0] OFS_METER = 8'h44;

  // ****************
  // Reset values
  // ****************
  localparam logic [HOLD_W-1:0] HOLD_DEF = 13'h0001;
  localparam logic [DELAY_W-1:0] DELAY_DEF = 12'h00A;
  localparam logic [RELAY_W-1:0] RELAY_DEF = 3'h1;
  localparam logic [LEVEL_W-1:0] ALARM_LVL_DEF [ELEMENTS] = '{15'h001E, 15'h0055, 15'h000A, 15'h000A};
  localparam logic [LEVEL_W-1:0] TRIP_LVL_DEF [ELEMENTS] = '{15'h001E, 15'h0050, 15'h000A, 15'h0019};

  // ****************
  // Timing
  // ****************
  localparam int TENTH_MS = 100;
  localparam int CLK_KHZ = 10000;
  localparam int TENTH_CYCLES = TENTH_MS * CLK_KHZ;
  localparam int TENTHS_PER_S = 10;

endpackage : pfvar_pkg

// ---- pickup_path.sv ----
`timescale 1ns/1ps

module pickup_path #(
  parameter int DW = pfvar_pkg::DELAY_W
) (
  // Clock and reset
  input wire logic mclk_i,
  input wire logic sys_rst_i,
  // Timing and qualification
  input wire logic tick_i,
  input wire logic cond_i,
  input wire logic armed_i,
  input wire logic clear_i,
  // Settings
  input pfvar_pkg::mode_type mode_i,
  input wire logic [DW-1:0] delay_i,
  // Result
  output logic active_o,
  output logic rise_o
);

  logic [DW-1:0] count;
  logic [DW-1:0] eff_delay;
  logic running;
  logic picked;

  // Zero delay is out of range; treat it as the smallest step
  assign eff_delay = (delay_i == '0) ? DW'(1) : delay_i;
  assign running = cond_i && armed_i && (mode_i != pfvar_pkg::MODE_OFF);
  assign picked = running && (count >= eff_delay);
  assign rise_o = picked && !active_o;

  // Delay timer restarts whenever the condition drops
  always_ff @(posedge mclk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      count <= '0;
    end else if (!running) begin
      count <= '0;
    end else if (tick_i && count < eff_delay) begin
      count <= count + DW'(1);
    end
  end

  // Output hold: latched keeps until cleared, set beats clear
  always_ff @(posedge mclk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      active_o <= 1'b0;
    end else begin
      unique case (mode_i)
        pfvar_pkg::MODE_LATCHED: begin
          if (picked) begin
            active_o <= 1'b1;
          end else if (clear_i) begin
            active_o <= 1'b0;
          end
        end
        pfvar_pkg::MODE_UNLATCHED: active_o <= picked;
        pfvar_pkg::MODE_OFF: active_o <= 1'b0;
        default: active_o <= 1'b0;
      endcase
    end
  end

endmodule : pickup_path

// ---- pfvar_asserts.sv ----
`timescale 1ns/1ps
// ****************
// Port checker
// ****************
module pfvar_asserts #(
  parameter int TENTH_CYCLES = 10
) (
  // Clock and reset
  input wire logic mclk_i,
  input wire logic sys_rst_i,
  // Register port
  input wire logic [7:0] reg_addr_i,
  input wire logic reg_rd_i,
  input wire logic [31:0] reg_rdata_o,
  // Front end and option
  input pfvar_pkg::meter_type meter_i,
  input wire logic reverse_run_i,
  input wire logic option_installed_i,
  // Relays and element state
  input wire logic alarm_relay_o,
  input wire logic trip_relay_o,
  input wire logic auxiliary_output_one_o,
  input wire logic auxiliary_output_two_o,
  input wire logic [3:0] alarm_o,
  input wire logic [3:0] trip_o,
  input wire logic [3:0] event_o,
  input pfvar_pkg::meter_type reported_o
);
  // One domain, so one clock and one disable for all
  default clocking @(posedge mclk_i); endclocking
  default disable iff (sys_rst_i);

  // Status read request
  sequence s_stat_rd;
    reg_rd_i && reg_addr_i == pfvar_pkg::OFS_STATUS;
  endsequence

  a_rdata_idle: assert property (!reg_rd_i |=> reg_rdata_o == '0)
    else $error("read data outside its slot");
  a_status_view: assert property (s_stat_rd |=> reg_rdata_o[7:0] == $past({trip_o, alarm_o}))
    else $error("status differs from element state");
  a_alarm_relay: assert property (alarm_relay_o |-> $past(alarm_o) != '0)
    else $error("alarm relay without alarm");
  a_trip_relay: assert property (trip_relay_o |-> $past(trip_o) != '0)
    else $error("trip relay without trip");
  a_aux_cause: assert property ((auxiliary_output_one_o || auxiliary_output_two_o) |->
    $past({alarm_o, trip_o}) != '0) else $error("aux relay without cause");
  a_option_off: assert property (!option_installed_i [*2] |=> {alarm_o, trip_o, event_o} == '0)
    else $error("element active without option");
  a_event_pulse: assert property (event_o != '0 |=> (event_o & $past(event_o)) == '0)
    else $error("event longer than one cycle");
  a_event_cause: assert property (event_o != '0 |-> (event_o & ~alarm_o) == '0)
    else $error("event without alarm");
  a_report_kw: assert property (!$past(sys_rst_i) |-> reported_o.kw == $past(meter_i.kw))
    else $error("reported kw altered");
  a_report_rev: assert property (!$past(sys_rst_i) |-> reported_o.leading ==
    ($past(meter_i.leading) ^ $past(reverse_run_i)) && reported_o.kvar ==
    ($past(reverse_run_i) ? -$past(meter_i.kvar) : $past(meter_i.kvar)))
    else $error("reverse correction wrong");
endmodule : pfvar_asserts

bind power_factor_kvar_protection pfvar_asserts #(.TENTH_CYCLES(TENTH_CYCLES)) u_asserts (
  .mclk_i, .sys_rst_i, .reg_addr_i, .reg_rd_i, .reg_rdata_o, .meter_i, .reverse_run_i,
  .option_installed_i, .alarm_relay_o, .trip_relay_o, .auxiliary_output_one_o,
  .auxiliary_output_two_o, .alarm_o, .trip_o, .event_o, .reported_o);

// ---- meter_front_end.sv ----
`timescale 1ns/1ps
// ****************
// Metering front end
// ****************
module meter_front_end #(
  parameter logic [14:0] KW = 15'h0032
) (
  // Clock and reset
  input wire logic mclk_i,
  input wire logic sys_rst_i,
  // Plant state
  input wire logic [14:0] kvar_mag_i,
  input wire logic generating_i,
  input wire logic leading_i,
  input wire logic [6:0] pf_i,
  input wire logic slow_i,
  // Measurement
  output pfvar_pkg::meter_type meter_o
);
  logic phase;

  // Slow mode refreshes every other cycle, like a lagging converter
  always_ff @(posedge mclk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      phase <= 1'b0;
      meter_o <= '0;
    end else begin
      phase <= ~phase;
      if (!slow_i || phase) begin
        meter_o.leading <= leading_i;
        meter_o.pf <= pf_i;
        meter_o.kvar <= generating_i ? -$signed({1'b0, kvar_mag_i}) : $signed({1'b0, kvar_mag_i});
        meter_o.kw <= $signed({1'b0, KW});
      end
    end
  end
endmodule : meter_front_end

// ---- tb_top.sv ----
`timescale 1ns/1ps
module tb_top;
  // ****************
  // Stimulus and observation
  // ****************
  logic mclk_i = 1'b0;
  logic sys_rst_i = 1'b1;
  logic [7:0] reg_addr_i = '0;
  logic [31:0] reg_wdata_i = '0;
  logic reg_wr_i = 1'b0;
  logic reg_rd_i = 1'b0;
  logic reverse_run_i = 1'b0;
  logic motor_running_i = 1'b1;
  logic motor_start_i = 1'b0;
  logic option_installed_i = 1'b1;
  logic latch_reset_i = 1'b0;
  logic [14:0] kmag = '0;
  logic gen = 1'b0;
  logic lead = 1'b0;
  logic [6:0] pf = 7'h63;
  logic slow = 1'b0;
  pfvar_pkg::meter_type meter;
  logic [31:0] rdata;
  logic arel, trel, auxiliary_output_one, auxiliary_output_two;
  logic [3:0] alarm, trip, evt;
  int fail_count = 0;
  int cmp_count = 0;
  int ta, tt, nev, am, tm, ar, tr, ev, da, dt, lv, tl, k, p, b, rv;
  int alv[4] = '{30, 85, 10, 10};
  int tlv[4] = '{30, 80, 10, 25};

  // Clock, 100 ns period
  always #50 mclk_i = ~mclk_i;

  // Front end model and design, one tenth shortened to 10 cycles
  meter_front_end fe (.mclk_i, .sys_rst_i, .kvar_mag_i(kmag), .generating_i(gen), .leading_i(lead),
    .pf_i(pf), .slow_i(slow), .meter_o(meter));
  power_factor_kvar_protection #(.TENTH_CYCLES(10)) uut (.mclk_i, .sys_rst_i, .reg_addr_i,
    .reg_wdata_i, .reg_wr_i, .reg_rd_i, .reg_rdata_o(rdata), .meter_i(meter), .reverse_run_i,
    .motor_running_i, .motor_start_i, .option_installed_i, .latch_reset_i, .alarm_relay_o(arel),
    .trip_relay_o(trel), .auxiliary_output_one_o(auxiliary_output_one), .auxiliary_output_two_o(auxiliary_output_two),
    .alarm_o(alarm), .trip_o(trip), .event_o(evt), .reported_o());

  // ****************
  // Tasks
  // ****************
  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      fail_count++;
      $display("[FAIL] %s expected %0h seen %0h", name, exp, seen);
    end
  endtask : check

  task automatic results();
    $display("comparisons %0d, mismatches %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : results

  task automatic wr(input int a, input int d);
    @(posedge mclk_i);
    reg_addr_i <= 8'(a);
    reg_wdata_i <= 32'(d);
    reg_wr_i <= 1'b1;
    @(posedge mclk_i);
    reg_wr_i <= 1'b0;
  endtask : wr

  // Read data is taken at the edge closing its only cycle
  task automatic rd(input int a);
    @(posedge mclk_i);
    reg_addr_i <= 8'(a);
    reg_rd_i <= 1'b1;
    @(posedge mclk_i);
    reg_rd_i <= 1'b0;
    @(posedge mclk_i);
  endtask : rd

  // Plant seen after correction; raw values undo the reverse flip
  task automatic plant(input int kv, input bit ld, input int pv, input bit rev);
    @(posedge mclk_i);
    reverse_run_i <= rev;
    gen <= (kv < 0) ^ rev;
    kmag <= 15'(kv < 0 ? -kv : kv);
    lead <= ld ^ rev;
    pf <= 7'(pv);
  endtask : plant

  task automatic watch(input int e, input int lim);
    ta = -1;
    tt = -1;
    nev = 0;
    for (int c = 0; c < lim && (ta < 0 || tt < 0); c++) begin
      @(posedge mclk_i);
      if (alarm[e] === 1'b1 && ta < 0) ta = c;
      if (trip[e] === 1'b1 && tt < 0) tt = c;
      if (evt[e] === 1'b1) nev++;
    end
  endtask : watch

  // Hang guard
  initial begin
    repeat (100000) @(posedge mclk_i);
    fail_count++;
    results();
  end

  // ****************
  // Main sequence
  // ****************
  initial begin
    void'($urandom(82878));
    repeat (4) @(posedge mclk_i);
    sys_rst_i <= 1'b0;
    for (int e = 0; e < 4; e++) begin
      rd(e * 16);
      check("ctrl default", rdata, 32'h0012_0001);
      rd(e * 16 + 4);
      check("alarm default", rdata, 32'(alv[e] | 10 << 15));
      rd(e * 16 + 8);
      check("trip default", rdata, 32'(tlv[e] | 10 << 15));
    end
    wr(56, 25000 | 2550 << 15);
    rd(56);
    check("level span", rdata, 32'(25000 | 2550 << 15));
    wr(0, 5000);
    rd(0);
    check("holdoff span", rdata, 5000);
    rd(128);
    check("unmapped", rdata, 0);
    $display("register test done");
    // Each element: random routing, delays and direction
    for (int e = 0; e < 4; e++) begin
      b = e * 16;
      am = 1 + e % 2;
      tm = 2 - e % 2;
      ar = $urandom_range(1, 7);
      tr = $urandom_range(1, 7);
      ev = $urandom_range(0, 1);
      da = $urandom_range(2, 6);
      dt = $urandom_range(2, 6);
      rv = $urandom_range(0, 1);
      lv = e < 2 ? $urandom_range(10, 90) : $urandom_range(20, 500);
      tl = e < 2 ? lv + 3 : lv - 3;
      k = e == 2 ? lv + 1 : e == 3 ? -lv - 1 : 0;
      p = e < 2 ? lv - 1 : 99;
      wr(b, am << 13 | tm << 15 | ar << 17 | tr << 20 | ev << 23);
      wr(b + 4, lv | da << 15);
      wr(b + 8, tl | dt << 15);
      plant(k, e == 0, p, rv);
      repeat ((da < dt ? da : dt) * 10 - 13) @(posedge mclk_i);
      plant(0, 0, 99, rv);
      repeat (4) @(posedge mclk_i);
      check("glitch", {alarm[e], trip[e]}, 0);
      plant(k, e == 0, p, rv);
      watch(e, 100);
      check("alarm time", ta >= da * 10 - 11 && ta <= da * 10 + 5, 1);
      check("trip time", tt >= dt * 10 - 11 && tt <= dt * 10 + 5, 1);
      check("events", nev, ev);
      if (ta < 0 || tt < 0) results();
      rd(64);
      check("status", rdata & 32'h10FF, 1 << 12 | 1 << (e + 4) | 1 << e);
      check("relays", {auxiliary_output_two, auxiliary_output_one, trel, arel}, {ar[2] | tr[2], ar[1] | tr[1], tr[0], ar[0]});
      rd(68);
      check("meter", rdata, {16'h0032, 16'(k)});
      plant(0, 0, 99, rv);
      repeat (5) @(posedge mclk_i);
      check("release", {alarm[e], trip[e]}, {am == 1, tm == 1});
      latch_reset_i <= 1'b1;
      @(posedge mclk_i);
      latch_reset_i <= 1'b0;
      repeat (3) @(posedge mclk_i);
      check("cleared", {alarm[e], trip[e], arel, trel, auxiliary_output_one, auxiliary_output_two}, 0);
      wr(b, 0);
      $display("element %0d test done", e);
    end
    // Option removal, stopped motor, then start hold-off
    wr(32, 2 << 13 | 1 << 17);
    wr(36, 20 | 3 << 15);
    option_installed_i <= 1'b0;
    plant(30, 0, 99, 0);
    repeat (60) @(posedge mclk_i);
    check("option off", alarm[2], 0);
    motor_running_i <= 1'b0;
    option_installed_i <= 1'b1;
    slow <= 1'b1;
    wr(32, 2 | 2 << 13 | 1 << 17);
    repeat (60) @(posedge mclk_i);
    check("stopped", alarm[2], 0);
    rd(64);
    check("blocked", rdata[10], 1);
    motor_running_i <= 1'b1;
    motor_start_i <= 1'b1;
    @(posedge mclk_i);
    motor_start_i <= 1'b0;
    watch(2, 100);
    check("holdoff", ta, -1);
    watch(2, 200);
    check("armed", ta >= 0, 1);
    check("trip off", trip[2], 0);
    $display("holdoff test done");
    results();
  end
endmodule : tb_top
